// ### rtl/sir_regs.sv
// Interrupt flag and measurement result registers behind a serial slave
`timescale 1ns/1ps
// Summary of operation
// - Flag register: bit5 command, bit4..2 proximity 3..1, bits1:0 ambient
// - Interrupt output high while any flag is set with its mask bit set
// - Reset clears the flag register and every result byte to zero
// - Visible result: low byte at 0x22, high byte at 0x23
// - Infrared result: low byte at 0x24, high byte at 0x25
// - Proximity one result: low byte at 0x26, high byte at 0x27
module sir_regs (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_meas_valid,
  input wire logic [15:0] i_visible_light_result,
  input wire logic [15:0] i_infrared_light_result,
  input wire logic [15:0] i_proximity_one_result,
  input wire logic [5:0] i_flag_set,
  input wire logic [5:0] i_irq_mask,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_int
);

  // ---------------- Sequencer clock domain ----------------
  logic [15:0] pend_vis_r, pend_vis_nxt, pend_ir_r, pend_ir_nxt;
  logic [15:0] pend_ps1_r, pend_ps1_nxt;
  logic pend_new_r, pend_new_nxt;
  logic [5:0] pend_flags_r, pend_flags_nxt;
  logic [15:0] xfer_vis_r, xfer_vis_nxt, xfer_ir_r, xfer_ir_nxt;
  logic [15:0] xfer_ps1_r, xfer_ps1_nxt;
  logic xfer_new_r, xfer_new_nxt;
  logic [5:0] xfer_flags_r, xfer_flags_nxt;
  logic req_r, req_nxt;
  logic ack_s;
  logic launch;

  localparam logic [5:0] SIR_FLAGS_RST_C = sir_pkg::SIR_FLAGS_RST;
  localparam logic [15:0] RES_RST = sir_pkg::SIR_RESULT_RST;

  // Collect events while a transfer is in flight; a newer measurement
  // replaces an unread one, which is why the host must keep pace
  always_comb
  begin
    launch = (req_r == ack_s) && (pend_new_r || (|pend_flags_r));
    pend_flags_nxt = (launch ? SIR_FLAGS_RST_C : pend_flags_r) | i_flag_set;
    pend_new_nxt = i_meas_valid | (pend_new_r & ~launch);
    pend_vis_nxt = i_meas_valid ? i_visible_light_result : pend_vis_r;
    pend_ir_nxt = i_meas_valid ? i_infrared_light_result : pend_ir_r;
    pend_ps1_nxt = i_meas_valid ? i_proximity_one_result : pend_ps1_r;
    xfer_vis_nxt = launch ? pend_vis_r : xfer_vis_r;
    xfer_ir_nxt = launch ? pend_ir_r : xfer_ir_r;
    xfer_ps1_nxt = launch ? pend_ps1_r : xfer_ps1_r;
    xfer_new_nxt = launch ? pend_new_r : xfer_new_r;
    xfer_flags_nxt = launch ? pend_flags_r : xfer_flags_r;
    req_nxt = req_r ^ launch;
  end

  // Transfer words stay frozen from request toggle until acknowledge
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pend_vis_r <= RES_RST;
      pend_ir_r <= RES_RST;
      pend_ps1_r <= RES_RST;
      pend_new_r <= 1'b0;
      pend_flags_r <= SIR_FLAGS_RST_C;
      xfer_vis_r <= RES_RST;
      xfer_ir_r <= RES_RST;
      xfer_ps1_r <= RES_RST;
      xfer_new_r <= 1'b0;
      xfer_flags_r <= SIR_FLAGS_RST_C;
      req_r <= 1'b0;
    end
    else
    begin
      pend_vis_r <= pend_vis_nxt;
      pend_ir_r <= pend_ir_nxt;
      pend_ps1_r <= pend_ps1_nxt;
      pend_new_r <= pend_new_nxt;
      pend_flags_r <= pend_flags_nxt;
      xfer_vis_r <= xfer_vis_nxt;
      xfer_ir_r <= xfer_ir_nxt;
      xfer_ps1_r <= xfer_ps1_nxt;
      xfer_new_r <= xfer_new_nxt;
      xfer_flags_r <= xfer_flags_nxt;
      req_r <= req_nxt;
    end
  end

  // ---------------- Link clock domain ----------------
  logic [8:0] link_s;
  logic scl_s, sda_s, req_s;
  logic [5:0] mask_s;
  logic seen_r, seen_nxt;
  logic apply;
  logic req_w;

  assign req_w = req_r;

  // Pins, request toggle and quasi-static mask all pass two flops
  sir_sync #(.W(9)) u_link_sync (
    .i_clk(i_link_clk),
    .i_rst(i_rst),
    .i_d({i_irq_mask, req_w, i_scl, i_sda}),
    .o_q(link_s)
  );
  assign {mask_s, req_s, scl_s, sda_s} = link_s;

  // Acknowledge toggle returns to the sequencer domain
  sir_sync #(.W(1)) u_ack_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(seen_r),
    .o_q(ack_s)
  );

  logic scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
  logic scl_rise, scl_fall, start_c, stop_c;
  sir_pkg::sir_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, rd_data;
  logic rw_r, rw_nxt, aph_r, aph_nxt, pph_r, pph_nxt, oe_r, oe_nxt;
  logic wr_en;
  logic [5:0] flags_r, flags_nxt;
  logic [15:0] vis_r, vis_nxt, ir_r, ir_nxt, ps1_r, ps1_nxt;
  logic int_r, int_nxt;

  // Read mux; reserved flag bits and unmapped offsets read zero
  always_comb
  begin
    case (ptr_r)
      sir_pkg::SIR_OFS_FLAGS: rd_data = {2'b00, flags_r};
      sir_pkg::SIR_OFS_VIS_LO: rd_data = vis_r[7:0];
      sir_pkg::SIR_OFS_VIS_HI: rd_data = vis_r[15:8];
      sir_pkg::SIR_OFS_IR_LO: rd_data = ir_r[7:0];
      sir_pkg::SIR_OFS_IR_HI: rd_data = ir_r[15:8];
      sir_pkg::SIR_OFS_PS1_LO: rd_data = ps1_r[7:0];
      sir_pkg::SIR_OFS_PS1_HI: rd_data = ps1_r[15:8];
      default: rd_data = sir_pkg::SIR_BYTE_RST;
    endcase
  end

  // Serial slave: sample on SCL rise, change SDA on SCL fall
  always_comb
  begin
    scl_d_nxt = scl_s;
    sda_d_nxt = sda_s;
    scl_rise = scl_s && !scl_d_r;
    scl_fall = !scl_s && scl_d_r;
    start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
    stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    aph_nxt = aph_r;
    pph_nxt = pph_r;
    oe_nxt = oe_r;
    wr_en = 1'b0;
    if (start_c)
    begin
      st_nxt = sir_pkg::SIR_ST_RECV;
      cnt_nxt = 4'h0;
      aph_nxt = 1'b1;
      oe_nxt = 1'b0;
    end
    else if (stop_c)
    begin
      st_nxt = sir_pkg::SIR_ST_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        sir_pkg::SIR_ST_IDLE: st_nxt = sir_pkg::SIR_ST_IDLE;
        sir_pkg::SIR_ST_RECV:
        begin
          if (scl_rise)
          begin
            sh_nxt = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == sir_pkg::SIR_BITS_PER_BYTE)
          begin
            cnt_nxt = 4'h0;
            if (aph_r)
            begin
              aph_nxt = 1'b0;
              if (sh_r[7:1] == sir_pkg::SIR_DEV_ADDR)
              begin
                oe_nxt = 1'b1;
                rw_nxt = sh_r[0];
                pph_nxt = !sh_r[0];
                st_nxt = sir_pkg::SIR_ST_ACK;
              end
              else
                st_nxt = sir_pkg::SIR_ST_IDLE;
            end
            else
            begin
              oe_nxt = 1'b1;
              st_nxt = sir_pkg::SIR_ST_ACK;
              if (pph_r)
              begin
                ptr_nxt = sh_r;
                pph_nxt = 1'b0;
              end
              else
              begin
                wr_en = 1'b1;
                ptr_nxt = ptr_r + 8'h01;
              end
            end
          end
        end
        sir_pkg::SIR_ST_ACK:
        begin
          if (scl_fall && rw_r)
          begin
            sh_nxt = rd_data;
            oe_nxt = ~rd_data[7];
            cnt_nxt = 4'h1;
            ptr_nxt = ptr_r + 8'h01;
            st_nxt = sir_pkg::SIR_ST_SEND;
          end
          else if (scl_fall)
          begin
            oe_nxt = 1'b0;
            st_nxt = sir_pkg::SIR_ST_RECV;
          end
        end
        sir_pkg::SIR_ST_SEND:
        begin
          if (scl_fall && cnt_r == sir_pkg::SIR_BITS_PER_BYTE)
          begin
            oe_nxt = 1'b0;
            st_nxt = sir_pkg::SIR_ST_RACK;
          end
          else if (scl_fall)
          begin
            oe_nxt = ~sh_r[6];
            sh_nxt = {sh_r[6:0], 1'b0};
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        // A not-acknowledge ends the read; an acknowledge fetches more
        sir_pkg::SIR_ST_RACK:
          if (scl_rise)
            st_nxt = sda_s ? sir_pkg::SIR_ST_IDLE : sir_pkg::SIR_ST_ACK;
        default: st_nxt = sir_pkg::SIR_ST_IDLE;
      endcase
    end
  end

  // Register bank; a sequencer update wins over a host write or clear
  always_comb
  begin
    apply = (req_s != seen_r);
    seen_nxt = req_s;
    flags_nxt = flags_r;
    vis_nxt = vis_r;
    ir_nxt = ir_r;
    ps1_nxt = ps1_r;
    if (wr_en)
    begin
      case (ptr_r)
        sir_pkg::SIR_OFS_FLAGS: flags_nxt = flags_r & ~sh_r[5:0];
        sir_pkg::SIR_OFS_VIS_LO: vis_nxt[7:0] = sh_r;
        sir_pkg::SIR_OFS_VIS_HI: vis_nxt[15:8] = sh_r;
        sir_pkg::SIR_OFS_IR_LO: ir_nxt[7:0] = sh_r;
        sir_pkg::SIR_OFS_IR_HI: ir_nxt[15:8] = sh_r;
        sir_pkg::SIR_OFS_PS1_LO: ps1_nxt[7:0] = sh_r;
        sir_pkg::SIR_OFS_PS1_HI: ps1_nxt[15:8] = sh_r;
        default: flags_nxt = flags_r;
      endcase
    end
    if (apply)
    begin
      flags_nxt = flags_nxt | xfer_flags_r;
      if (xfer_new_r)
      begin
        vis_nxt = xfer_vis_r;
        ir_nxt = xfer_ir_r;
        ps1_nxt = xfer_ps1_r;
      end
    end
    int_nxt = |(flags_r & mask_s);
  end

  // Link-domain state; everything clears on reset except the SCL and SDA delay flops, which preset high
  always_ff @(posedge i_link_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      st_r <= sir_pkg::SIR_ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= sir_pkg::SIR_BYTE_RST;
      ptr_r <= sir_pkg::SIR_BYTE_RST;
      rw_r <= 1'b0;
      aph_r <= 1'b0;
      pph_r <= 1'b0;
      oe_r <= 1'b0;
      seen_r <= 1'b0;
      flags_r <= SIR_FLAGS_RST_C;
      vis_r <= RES_RST;
      ir_r <= RES_RST;
      ps1_r <= RES_RST;
      int_r <= 1'b0;
    end
    else
    begin
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      aph_r <= aph_nxt;
      pph_r <= pph_nxt;
      oe_r <= oe_nxt;
      seen_r <= seen_nxt;
      flags_r <= flags_nxt;
      vis_r <= vis_nxt;
      ir_r <= ir_nxt;
      ps1_r <= ps1_nxt;
      int_r <= int_nxt;
    end
  end

  // Open-drain data line only ever pulls low
  always_ff @(posedge i_link_clk or posedge i_rst)
  begin
    if (i_rst)
      o_sda_out <= 1'b0;
    else
      o_sda_out <= 1'b0;
  end

  assign o_sda_oe = oe_r;
  assign o_int = int_r;

  // ---------------- Checks ----------------
  default clocking cb @(posedge i_link_clk); endclocking
  default disable iff (i_rst);

  a_int_raise: assert property (
    |(flags_r & mask_s) |=> o_int) else $error("interrupt not raised");
  a_int_drop: assert property (
    !(|(flags_r & mask_s)) |=> !o_int) else $error("interrupt not dropped");
  a_set_wins: assert property (
    apply && xfer_flags_r[0] |=> flags_r[0])
    else $error("flag set lost");
  a_w1c_clear: assert property (
    wr_en && ptr_r == sir_pkg::SIR_OFS_FLAGS && sh_r[2] && !apply
    |=> !flags_r[2]) else $error("flag not cleared by one");
  a_reset_zero: assert property (
    $past(i_rst) |-> flags_r == 6'h00 && vis_r == 16'h0000
    && ir_r == 16'h0000 && ps1_r == 16'h0000)
    else $error("register not zero after reset");
  a_vis_load: assert property (
    apply && xfer_new_r |=> vis_r == $past(xfer_vis_r))
    else $error("visible result not loaded");
  a_ir_load: assert property (
    apply && xfer_new_r |=> ir_r == $past(xfer_ir_r))
    else $error("infrared result not loaded");
  a_ps1_hi_read: assert property (
    st_r == sir_pkg::SIR_ST_ACK && scl_fall && rw_r && !start_c && !stop_c
    && ptr_r == sir_pkg::SIR_OFS_PS1_HI |=> sh_r == $past(ps1_r[15:8]))
    else $error("proximity high byte misplaced");
  a_ack_drive: assert property (
    st_r == sir_pkg::SIR_ST_ACK && !rw_r |-> o_sda_oe)
    else $error("acknowledge not driven");
  a_pend_new: assert property (@(posedge i_clk) disable iff (i_rst)
    i_meas_valid |=> pend_new_r ##1 1'b1)
    else $error("measurement not held");

  c_int_set: cover property (!o_int ##1 o_int);
  c_flag_clear: cover property (wr_en && ptr_r == sir_pkg::SIR_OFS_FLAGS);
  c_result_load: cover property (apply && xfer_new_r);
  c_byte_read: cover property (st_r == sir_pkg::SIR_ST_SEND ##[1:400]
    st_r == sir_pkg::SIR_ST_RACK);

endmodule

// ### rtl/sir_pkg.sv
// Shared constants and types for the interrupt flag and result register bank
package sir_pkg;

  // Register offsets on the two-wire serial bus
  localparam logic [7:0] SIR_OFS_FLAGS = 8'h21;
  localparam logic [7:0] SIR_OFS_VIS_LO = 8'h22;
  localparam logic [7:0] SIR_OFS_VIS_HI = 8'h23;
  localparam logic [7:0] SIR_OFS_IR_LO = 8'h24;
  localparam logic [7:0] SIR_OFS_IR_HI = 8'h25;
  localparam logic [7:0] SIR_OFS_PS1_LO = 8'h26;
  localparam logic [7:0] SIR_OFS_PS1_HI = 8'h27;

  // Bus address of the device; a plain default, set per system
  localparam logic [6:0] SIR_DEV_ADDR = 7'h2C;

  // Interrupt flag field positions
  localparam int SIR_FLAG_W = 6;
  localparam int SIR_BIT_CMD = 5;
  localparam int SIR_BIT_PS3 = 4;
  localparam int SIR_BIT_PS2 = 3;
  localparam int SIR_BIT_PS1 = 2;
  localparam int SIR_AMB_MSB = 1;
  localparam int SIR_AMB_LSB = 0;

  // Values after reset
  localparam logic [5:0] SIR_FLAGS_RST = 6'h00;
  localparam logic [15:0] SIR_RESULT_RST = 16'h0000;
  localparam logic [7:0] SIR_BYTE_RST = 8'h00;

  // Bits in one serial byte
  localparam logic [3:0] SIR_BITS_PER_BYTE = 4'h8;

  // Serial engine states, Gray coded along the usual path
  typedef enum logic [2:0] {
    SIR_ST_IDLE = 3'b000,
    SIR_ST_RECV = 3'b001,
    SIR_ST_ACK = 3'b011,
    SIR_ST_SEND = 3'b010,
    SIR_ST_RACK = 3'b110
  } sir_state_t;

endpackage

// ### rtl/sir_sync.sv
// Two-flop level synchroniser, one chain per bit
`timescale 1ns/1ps
module sir_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1)
    begin : g_bit
      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          meta_r[gi] <= 1'b0;
          o_q[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= i_d[gi];
          o_q[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule

// ### tb/sir_host.sv
// Two-wire bus host model that drives the serial pins of the register bank
`timescale 1ns/1ps
module sir_host (
  input wire logic i_lclk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // Half bit time in link cycles; the slave needs SCL low for 5 or more
  localparam int HALF = 6;

  // Idle bus: SCL stands high and SDA is released to its pull-up
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic tick(input int n);
    // Pins move on the falling edge, clear of the slave's sampling edge
    repeat (n) @(negedge i_lclk);
  endtask

  // Start condition, also used as repeated start with SCL low on entry
  task automatic start_c();
    o_sda_low = 1'b0;
    tick(HALF);
    o_scl = 1'b1;
    tick(HALF);
    o_sda_low = 1'b1;
    tick(HALF);
    o_scl = 1'b0;
  endtask

  // Stop condition; SDA leaves the pull-up only while SCL is low
  task automatic stop_c();
    tick(2);
    o_sda_low = 1'b1;
    tick(HALF);
    o_scl = 1'b1;
    tick(HALF);
    o_sda_low = 1'b0;
    tick(HALF);
  endtask

  // One bit; SDA moves two cycles after SCL fall, sampled at end of high
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    o_sda_low = ~b;
    tick(HALF);
    o_scl = 1'b1;
    tick(HALF);
    r = i_sda;
    o_scl = 1'b0;
  endtask

  // Eight bits MSB first, then the acknowledge bit
  task automatic byte_x(input logic [7:0] d, input logic a,
                        output logic [7:0] r, output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(a, nak);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] ofs,
                    input logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic k0, k1, k2;
    start_c();
    byte_x({a, 1'b0}, 1'b1, r, k0);
    byte_x(ofs, 1'b1, r, k1);
    byte_x(d, 1'b1, r, k2);
    stop_c();
    nak = k0 | k1 | k2;
  endtask

  // Pointer write, repeated start, n bytes with the last one NACKed;
  // results are fetched after the interrupt, before the next measurement
  task automatic rd(input logic [6:0] a, input logic [7:0] ofs,
                    input int n, output logic [63:0] v, output logic nak);
    logic [7:0] r;
    logic k0, k1, k2, k;
    v = '0;
    start_c();
    byte_x({a, 1'b0}, 1'b1, r, k0);
    byte_x(ofs, 1'b1, r, k1);
    start_c();
    byte_x({a, 1'b1}, 1'b1, r, k2);
    for (int i = 0; i < n; i++)
    begin
      byte_x(8'hFF, (i == n - 1), r, k);
      v[8*i +: 8] = r;
    end
    stop_c();
    nak = k0 | k1 | k2;
  endtask
endmodule

// ### tb/sensor_irq_and_result_regs_tb.sv
// Self-checking bench for the flag and result register bank
`timescale 1ns/1ps
module sensor_irq_and_result_regs_tb;
  typedef struct packed {
    logic [15:0] vis;
    logic [15:0] ir;
    logic [15:0] ps1;
    logic [47:0] exp;
  } sir_row_t;

  logic i_clk, i_rst, lclk, meas, scl, host_low, sda, sda_oe, irq, nak;
  logic sdo;
  logic [15:0] vis, ir, ps1;
  logic [5:0] fset, mask;
  logic [63:0] v;
  int num_errors = 0;
  int n_tests = 0;
  // Results in, bytes 0x22..0x27 out, low byte first
  sir_row_t rows [3] = '{
    '{16'h1234, 16'h5678, 16'h9ABC, 48'h9ABC_5678_1234},
    '{16'hFFFF, 16'h0001, 16'h8000, 48'h8000_0001_FFFF},
    '{16'h00FF, 16'hFF00, 16'hA55A, 48'hA55A_FF00_00FF}
  };

  // Open-drain wire with pull-up; either party may pull it low
  assign sda = ~(host_low | sda_oe);

  sir_regs u_sir_regs (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_link_clk(lclk),
    .i_scl(scl),
    .i_sda(sda),
    .i_meas_valid(meas),
    .i_visible_light_result(vis),
    .i_infrared_light_result(ir),
    .i_proximity_one_result(ps1),
    .i_flag_set(fset),
    .i_irq_mask(mask),
    .o_sda_out(sdo),
    .o_sda_oe(sda_oe),
    .o_int(irq)
  );

  sir_host u_sir_host (
    .i_lclk(lclk),
    .i_sda(sda),
    .o_scl(scl),
    .o_sda_low(host_low)
  );

  // Clocks; the link clock is offset so the two never line up
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end

  task automatic check(input string name, input logic [63:0] exp,
                       input logic [63:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Sequencer pulses last one i_clk cycle, launched on the falling edge
  task automatic pulse(input logic [5:0] f, input logic m);
    @(negedge i_clk);
    fset = f;
    meas = m;
    @(negedge i_clk);
    fset = '0;
    meas = 1'b0;
  endtask

  // The interrupt crosses domains, so allow it a bounded settling time
  task automatic wait_int(input logic e);
    for (int i = 0; i < 40 && irq !== e; i++)
      @(negedge lclk);
    check("interrupt", 64'(e), 64'(irq));
  endtask

  task automatic set_mask(input logic [5:0] m);
    @(negedge i_clk);
    mask = m;
  endtask

  // Hang guard, about twice the expected run length
  initial
  begin
    repeat (60000) @(posedge i_clk);
    num_errors++;
    $display("Timeout reached");
    summarize();
  end

  initial
  begin
    i_rst = 1'b1;
    meas = 1'b0;
    fset = '0;
    mask = '0;
    vis = '0;
    ir = '0;
    ps1 = '0;
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(posedge lclk);
    u_sir_host.rd(sir_pkg::SIR_DEV_ADDR, 8'h21, 7, v, nak);
    check("reset bytes", 64'h0, v);
    check("reset int", 64'h0, 64'(irq));
    check("sda value", 64'h0, 64'(sdo));
    $display("Test reset values done");

    // Each row: measurement and flag, interrupt, read, clear
    set_mask(6'h04);
    foreach (rows[i])
    begin
      @(negedge i_clk);
      vis = rows[i].vis;
      ir = rows[i].ir;
      ps1 = rows[i].ps1;
      pulse(6'h04, 1'b1);
      wait_int(1'b1);
      u_sir_host.rd(sir_pkg::SIR_DEV_ADDR, 8'h22, 6, v, nak);
      check("results", {16'h0, rows[i].exp}, v);
      u_sir_host.wr(sir_pkg::SIR_DEV_ADDR, 8'h21, 8'h04, nak);
      wait_int(1'b0);
    end
    $display("Test result rows done");

    // Every flag bit alone: position, masking, write-one clear
    for (int b = 0; b < 6; b++)
    begin
      set_mask(~(6'h01 << b));
      pulse(6'h01 << b, 1'b0);
      u_sir_host.rd(sir_pkg::SIR_DEV_ADDR, 8'h21, 1, v, nak);
      check("flag bit", 64'(6'h01 << b), v);
      check("masked int", 64'h0, 64'(irq));
      set_mask(6'h01 << b);
      wait_int(1'b1);
      u_sir_host.wr(sir_pkg::SIR_DEV_ADDR, 8'h21, 8'(6'h01 << b), nak);
      wait_int(1'b0);
    end
    $display("Test flag bits done");

    // Reserved bits do not stick and a zero write clears nothing
    pulse(6'h3F, 1'b0);
    set_mask(6'h3F);
    u_sir_host.wr(sir_pkg::SIR_DEV_ADDR, 8'h21, 8'hC0, nak);
    u_sir_host.rd(sir_pkg::SIR_DEV_ADDR, 8'h21, 1, v, nak);
    check("reserved", 64'h3F, v);
    wait_int(1'b1);
    u_sir_host.wr(sir_pkg::SIR_DEV_ADDR, 8'h21, 8'h3F, nak);
    wait_int(1'b0);
    $display("Test reserved bits done");

    // Host write to a result byte, and a read running past the bank
    u_sir_host.wr(sir_pkg::SIR_DEV_ADDR, 8'h24, 8'h3C, nak);
    u_sir_host.rd(sir_pkg::SIR_DEV_ADDR, 8'h24, 2, v, nak);
    check("ir bytes", 64'hFF3C, v);
    u_sir_host.rd(sir_pkg::SIR_DEV_ADDR, 8'h27, 2, v, nak);
    check("ps1 high edge", 64'h00A5, v);
    $display("Test result access done");

    // Foreign address gets no acknowledge
    u_sir_host.wr(sir_pkg::SIR_DEV_ADDR + 7'h01, 8'h21, 8'hFF, nak);
    check("foreign nak", 64'h1, 64'(nak));
    $display("Test foreign address done");

    // Reset in mid-run wipes results and flags
    pulse(6'h04, 1'b0);
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(posedge lclk);
    u_sir_host.rd(sir_pkg::SIR_DEV_ADDR, 8'h21, 7, v, nak);
    check("rerun reset", 64'h0, v);
    check("rerun int", 64'h0, 64'(irq));
    $display("Test mid-run reset done");
    summarize();
  end
endmodule
